// ### clock_divider_pkg.sv
package clock_divider_pkg;

  // =====================================================================
  // Register map and field layout.
  // =====================================================================
  localparam logic [15:0] clock_divide_control_offset = 16'hff5d;
  // The printed offset is a word index, so the byte address is four times it.
  localparam logic [31:0] clock_divide_control_addr = {14'h0, clock_divide_control_offset, 2'h0};
  localparam logic [31:0] standby_control_addr = 32'h0000ff60;
  localparam logic [31:0] prescaler_status_addr = 32'h0000ff64;
  localparam int ctrl_lane = 0;
  localparam logic [7:0] clock_divide_control_reset = 8'hfc;
  localparam logic [5:0] reserved_bits_value = 6'h3f;
  localparam int ratio_select_low = 0;
  localparam int ratio_select_high = 1;

  // =====================================================================
  // Clocking figures.
  // =====================================================================
  localparam int duty_threshold_khz = 5000;
  localparam int prescale_width = 12;
  localparam int external_clock_settle_delay_us = 500;
  localparam int clock_rate_mhz = 40;
  localparam int settle_cycles = external_clock_settle_delay_us * clock_rate_mhz;

  // AXI4-Lite response codes.
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  typedef enum logic [1:0] {ratio_ratio_select_high, ratio_div2, ratio_div4, ratio_div8} ratio_e;

endpackage

// ### duty_corrector.sv
`timescale 1ns/100ps

// Regenerates an even-duty pulse stream from the synchronised oscillator.
// Each rising oscillator edge becomes a one-cycle tick, so the divider sees
// equal spacing whatever the incoming high/low ratio. With correction on, an
// edge only counts if its high level still stands one sample later.
module duty_corrector
  import clock_divider_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic osc_sync,
  input wire logic correct_enable,
  output logic osc_tick
);

  logic osc_prev;
  logic raw_edge;
  logic edge_pending;

  // =====================================================================
  // Edge detect on the agreed oscillator level.
  // =====================================================================
  assign raw_edge = osc_sync && !osc_prev;

  // Record the level and remember an edge for one cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc_prev <= 1'b0;
      edge_pending <= 1'b0;
    end
    else
    begin
      osc_prev <= osc_sync;
      edge_pending <= raw_edge;
    end
  end

  // Corrected path rejects a runt high phase from a skewed fast input,
  // at the cost of one cycle of latency; the raw path passes the edge as it comes.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc_tick <= 1'b0;
    end
    else if (correct_enable)
    begin
      osc_tick <= edge_pending && osc_sync;
    end
    else
    begin
      osc_tick <= raw_edge;
    end
  end

endmodule // duty_corrector

// ### system_clock_divider.sv
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps

// How it works
// - Duty-correct oscillator at or above 5 MHz.
// - Prescalers give system clock divided 2..4096.
// - Divider takes the corrected clock only.
// - Ratio changes live, no reset needed.
// - Two low bits pick 1, 2, 4, 8.
// - Reset and hardware standby load 0xfc.
// - Software standby keeps the ratio.
// - Upper six bits ignore writes, read one.
// - Eight-bit register at offset 0xff5d.
// - Divided clock drives the clock output pin.
// - Modules time from divided system clock.
// - Standby settle wait counted in system clocks.
module system_clock_divider
  import clock_divider_pkg::*;
#(
  parameter int osc_khz = 20000,
  parameter int settle_count = settle_cycles
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic oscillator_input_pin,
  input wire logic hardware_standby,
  input wire logic software_standby,
  input wire logic clock_out_enable,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic system_clock_pin,
  output logic system_tick,
  output logic [prescale_width-1:0] prescaler_ticks,
  output logic settle_done
);

  // Refuse figures that the counters cannot serve.
  if (osc_khz < 1 || settle_count < 1)
  begin : bad_params
    $error("system_clock_divider: osc_khz and settle_count must be positive");
  end

  // Ratio code to divide count minus one, used by load and boundary logic.
  function automatic logic [2:0] ratio_last(input logic [1:0] code);
    case (ratio_e'(code))
      ratio_ratio_select_high: ratio_last = 3'h0;
      ratio_div2: ratio_last = 3'h1;
      ratio_div4: ratio_last = 3'h3;
      default: ratio_last = 3'h7;
    endcase
  endfunction

  // =====================================================================
  // Oscillator pin synchroniser: three stages, a change counts once
  // the second and third agree.
  // =====================================================================
  logic [2:0] osc_sync;
  logic osc_level;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc_sync <= 3'h0;
      osc_level <= 1'b0;
    end
    else
    begin
      osc_sync <= {osc_sync[1:0], oscillator_input_pin};
      if (osc_sync[1] == osc_sync[2])
      begin
        osc_level <= osc_sync[2];
      end
    end
  end

  // =====================================================================
  // Duty correction in front of the divider.
  // =====================================================================
  logic osc_tick;
  logic correct_enable;

  assign correct_enable = (osc_khz >= duty_threshold_khz);

  duty_corrector corrector
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .osc_sync(osc_level),
    .correct_enable(correct_enable),
    .osc_tick(osc_tick)
  );

  // =====================================================================
  // Register file.
  // =====================================================================
  logic [1:0] ratio_code;
  logic [1:0] next_ratio;
  logic aw_held;
  logic w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] read_word;
  logic read_hit;

  // Address and data may arrive in either order; each is held until both are in.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= resp_okay;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held && !s_axi_bvalid)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr[31:2] == clock_divide_control_addr[31:2] ||
                        aw_addr[31:2] == standby_control_addr[31:2] ||
                        aw_addr[31:2] == prescaler_status_addr[31:2]) ? resp_okay : resp_slverr;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Only the two ratio bits store; the reserved bits never latch.
  always_comb
  begin
    next_ratio = ratio_code;
    if (aw_held && w_held && !s_axi_bvalid &&
        aw_addr[31:2] == clock_divide_control_addr[31:2] && w_strb[ctrl_lane])
    begin
      next_ratio = w_data[8*ctrl_lane+ratio_select_high -: 2];
    end
  end

  // Software standby leaves the ratio alone; hardware standby reloads it.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || hardware_standby)
    begin
      ratio_code <= clock_divide_control_reset[1:0];
    end
    else
    begin
      ratio_code <= next_ratio;
    end
  end

  // Read side: the control byte sits in its own lane of the aligned word.
  always_comb
  begin
    read_word = 32'h0;
    read_hit = 1'b1;
    if (s_axi_araddr[31:2] == clock_divide_control_addr[31:2])
    begin
      read_word[8*ctrl_lane +: 8] = {reserved_bits_value, ratio_code};
    end
    else if (s_axi_araddr[31:2] == standby_control_addr[31:2])
    begin
      read_word = {30'h0, software_standby, hardware_standby};
    end
    else if (s_axi_araddr[31:2] == prescaler_status_addr[31:2])
    begin
      read_word = {19'h0, settle_done, prescaler_ticks};
    end
    else
    begin
      read_hit = 1'b0;
    end
  end

  // One read outstanding; answer in the cycle after the address is taken.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= resp_okay;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= read_word;
        s_axi_rresp <= read_hit ? resp_okay : resp_slverr;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // =====================================================================
  // Frequency divider: counts corrected oscillator ticks only.
  // =====================================================================
  logic [2:0] div_count;
  logic [2:0] active_last;
  logic div_wrap;

  assign div_wrap = osc_tick && (div_count == active_last);

  // The live ratio is swapped only at a wrap so no phase is clipped.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_count <= 3'h0;
      active_last <= 3'h0;
      system_tick <= 1'b0;
    end
    else
    begin
      system_tick <= div_wrap;
      if (div_wrap)
      begin
        div_count <= 3'h0;
        active_last <= ratio_last(ratio_code);
      end
      else if (osc_tick)
      begin
        div_count <= div_count + 3'h1;
      end
    end
  end

  // Output pin toggles per system tick: half the tick rate, even duty.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      system_clock_pin <= 1'b1;
    end
    else if (!clock_out_enable)
    begin
      system_clock_pin <= 1'b1;
    end
    else if (div_wrap)
    begin
      system_clock_pin <= ~system_clock_pin;
    end
  end

  // =====================================================================
  // Prescalers: bit n pulses once per 2^(n+1) system ticks.
  // =====================================================================
  logic [prescale_width-1:0] prescale_count;
  logic [prescale_width-1:0] next_prescale;

  assign next_prescale = prescale_count + {{(prescale_width-1){1'b0}}, 1'b1};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prescale_count <= '0;
      prescaler_ticks <= '0;
    end
    else if (div_wrap)
    begin
      prescale_count <= next_prescale;
      prescaler_ticks <= ~prescale_count & next_prescale;
    end
    else
    begin
      prescaler_ticks <= '0;
    end
  end

  // =====================================================================
  // Standby exit settle wait, counted in system ticks.
  // =====================================================================
  logic [31:0] settle_left;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      settle_left <= 32'h0;
      settle_done <= 1'b1;
    end
    else
    begin
      if (software_standby)
      begin
        settle_done <= 1'b0;
        settle_left <= 32'(settle_count);
      end
      else if (!settle_done && div_wrap)
      begin
        settle_left <= settle_left - 32'h1;
        settle_done <= (settle_left == 32'h1);
      end
    end
  end

endmodule // system_clock_divider

// ### osc_source.sv
`timescale 1ns/100ps
// ============
// Far-side oscillator.
// ============
// Free-running 8 MHz source with a 40 percent high phase. At 8 MHz the
// slowest ratio still gives a 1 MHz system clock, so every code is legal.
module osc_source
(
  output logic osc_out
);
  // The 7 ns offset keeps edges clear of the bench clock edges.
  initial
  begin
    osc_out = 1'h0;
    #7;
    forever
    begin
      #75 osc_out = 1'h1;
      #50 osc_out = 1'h0;
    end
  end
endmodule // osc_source

// ### system_clock_divider_sva.sv
`timescale 1ns/100ps
// ============
// Port checker.
// ============
module divider_checker
  import clock_divider_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic software_standby,
  input wire logic clock_out_enable,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic system_clock_pin,
  input wire logic system_tick,
  input wire logic [prescale_width-1:0] prescaler_ticks,
  input wire logic settle_done
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [31:0] last_ar;
  // The read data can only be judged against the address it answers.
  always_ff @(posedge aclk)
  begin
    if (s_axi_arvalid && s_axi_arready)
    begin
      last_ar <= s_axi_araddr;
    end
  end
  tick_gap_a: assert property (system_tick |=> !system_tick [*4]) else $error("tick too soon");
  prescale_gap_a: assert property (prescaler_ticks[0] |=> !prescaler_ticks[0] [*8])
    else $error("prescaler pulse too soon");
  pin_hold_a: assert property (!clock_out_enable ##1 !clock_out_enable |-> system_clock_pin)
    else $error("pin not held high");
  pin_cause_a: assert property ($changed(system_clock_pin) && $past(clock_out_enable)
    |-> system_tick || $past(system_tick)) else $error("pin moved without tick");
  write_resp_a: assert property (s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("no write answer");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  read_resp_a: assert property (s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  reserved_ones_a: assert property (s_axi_rvalid && last_ar == clock_divide_control_addr
    |-> s_axi_rdata[31:2] == 30'h3f && s_axi_rresp == resp_okay) else $error("reserved bits wrong");
  settle_low_a: assert property (software_standby |=> !settle_done) else $error("settle flag high");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(settle_done));
endmodule // divider_checker

bind system_clock_divider divider_checker checker_i (.*);

// ### test_system_clock_divider.sv
`timescale 1ns/100ps
// ============
// Self-checking bench.
// ============
module test_system_clock_divider import clock_divider_pkg::*;;
  logic aclk, oscillator_input_pin, aresetn = 1'h0;
  logic hardware_standby = 1'h0, software_standby = 1'h0, clock_out_enable = 1'h1;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic system_clock_pin, system_tick, settle_done;
  logic [prescale_width-1:0] prescaler_ticks;
  int bad_count = 0, checks_done = 0;
  int pre_gap [4];
  bit pre_seen [4];

  system_clock_divider #(.settle_count(4)) DUT (.*);
  osc_source far_end (.osc_out(oscillator_input_pin));

  // The 40 MHz clock.
  initial
  begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Both write channels go out together; each drops when taken.
  task automatic axi_write(input logic [31:0] a, d, input logic [3:0] s, output logic [1:0] rs);
    bit aw, w;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
      begin
        aw = 1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wready)
      begin
        w = 1;
        s_axi_wvalid <= 1'h0;
      end
    end while (!(aw && w));
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  // Reserved bits must read as ones around the ratio field.
  task automatic check_ratio(input logic [1:0] r);
    logic [31:0] d;
    logic [1:0] rs;
    axi_read(clock_divide_control_addr, d, rs);
    cmp("ratio_word", {24'h0, 6'h3f, r}, d);
    cmp("ratio_resp", resp_okay, rs);
  endtask

  // Cycles from one system tick to the next.
  task automatic tick_gap(output int c);
    c = 0;
    do @(posedge aclk); while (!system_tick);
    do
    begin
      @(posedge aclk);
      c++;
    end while (!system_tick);
  endtask

  // Prescaler taps are counted in system ticks, so the ratio must not matter.
  always @(posedge aclk)
  begin
    for (int n = 0; n < 4; n++)
    begin
      if (!aresetn || software_standby || hardware_standby)
        pre_seen[n] = 0;
      else if (prescaler_ticks[n])
      begin
        if (pre_seen[n])
          cmp("prescale", 32'h2 << n, pre_gap[n]);
        pre_seen[n] = 1;
        pre_gap[n] = 0;
      end
      if (system_tick)
        pre_gap[n]++;
    end
  end

  initial
  begin
    repeat (30000) @(posedge aclk);
    bad_count++;
    finish_test();
  end

  initial
  begin
    logic [31:0] d;
    logic [1:0] rs, r, old;
    int c;
    void'($urandom(44));
    repeat (5) @(posedge aclk);
    // Reset stays low while the far-side oscillator starts up.
    aresetn <= 1'h1;
    check_ratio(2'h0);
    // Every code first, then random ones, with noise in the ignored bits.
    old = 2'h0;
    for (int i = 0; i < 7; i++)
    begin
      // With the 8 MHz source no code takes the system clock below 1 MHz.
      r = (i < 4) ? 2'(i) : 2'($urandom);
      d = $urandom;
      axi_write(clock_divide_control_addr, {d[31:2], r}, 4'h1 | 4'($urandom), rs);
      cmp("wresp", resp_okay, rs);
      check_ratio(r);
      tick_gap(c);
      cmp("first_gap", 1, c == (5 << old) || c == (5 << r));
      tick_gap(c);
      cmp("gap", 5 << r, c);
      old = r;
    end
    // Without byte lane zero the ratio stays; unmapped words are refused.
    axi_write(clock_divide_control_addr, {30'h0, ~old}, 4'he, rs);
    cmp("lane_wresp", resp_okay, rs);
    axi_write(32'h10, 32'hffffffff, 4'hf, rs);
    cmp("bad_wresp", resp_slverr, rs);
    axi_read(32'h10, d, rs);
    cmp("bad_rresp", resp_slverr, rs);
    cmp("bad_rdata", 32'h0, d);
    check_ratio(old);
    // Software standby keeps the ratio; settling counts system ticks.
    axi_write(clock_divide_control_addr, 32'h1, 4'h1, rs);
    software_standby <= 1'h1;
    repeat (20) @(posedge aclk);
    cmp("settle_low", 1'h0, settle_done);
    software_standby <= 1'h0;
    c = 0;
    do
    begin
      @(posedge aclk);
      c++;
    end while (!settle_done);
    cmp("settle_time", 1, c >= 32 && c <= 72);
    check_ratio(2'h1);
    hardware_standby <= 1'h1;
    repeat (3) @(posedge aclk);
    hardware_standby <= 1'h0;
    check_ratio(2'h0);
    // Pin held high while disabled, then toggles once per tick.
    clock_out_enable <= 1'h0;
    repeat (3) @(posedge aclk);
    c = 0;
    repeat (60)
    begin
      @(posedge aclk);
      c += !system_clock_pin;
    end
    cmp("pin_high", 0, c);
    clock_out_enable <= 1'h1;
    repeat (20) @(posedge aclk);
    c = 0;
    d[0] = system_clock_pin;
    repeat (64)
    begin
      @(posedge aclk);
      c += (system_clock_pin !== d[0]);
      d[0] = system_clock_pin;
    end
    cmp("pin_toggles", 1, c >= 12 && c <= 13);
    finish_test();
  end
endmodule // test_system_clock_divider
